// file: design/osd_ctrl.sv
// oscillator select, switch sequencer, doze ratio and fast rc control
// Notes on behaviour
// - switching only when monitor cfg bit1 zero
// - fail-safe monitor only when cfg 00
// - reset source from initial source config
// - unprogrammed default is postscaled fast rc
// - current source read-only in bits 14-12
// - new source bits 10-8, reset from cfg
// - freeze plus monitor locks selections
// - pin-map freeze needs unlock; one-way option
// - pll settled reads synchronised lock
// - pll settled cleared on switch, non-pll
// - clock fail flag set by monitor, clear-only
// - secondary enable bit drives secondary oscillator
// - request bit starts switch, cleared at end
// - recover on interrupt clears ratio enable
// - ratio code gives 1:2^code
// - ratio applied only while enable set
// - postscaler divides 1..64 or 256
// - trim field is signed six-bit value
// - primary submode fixed by configuration
// - switching disabled: current follows configuration
// - switching disabled: request held at zero
// - equal sources abort the switch
// - start, wait ready, 10 cycles, switch
// - byte writes need their unlock pair
//
// The implementer's own choices: the register offsets and strobed register access.
module osd_ctrl (
  input wire logic clk, // system clock
  input wire logic nrst, // synchronous reset, low active
  input wire logic [1:0] switch_monitor_cfg, // config bits 7:6
  input wire logic [2:0] initial_source_cfg, // config reset source
  input wire logic [1:0] primary_submode_cfg, // config primary submode
  input wire logic one_way_freeze_cfg, // config one-way pin freeze
  input wire logic [1:0] addr, // register index
  input wire logic [15:0] wdata, // write data
  input wire logic [1:0] wbyte, // byte lanes of a write
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  input wire logic intr_evt, // any interrupt, async
  input wire logic clock_failed, // monitor detected failure, async
  input wire logic source_ready, // new source running, async
  input wire logic pll_locked, // pll lock, async
  input wire logic new_clk_tick, // one per new clock cycle, async
  output logic [15:0] rdata, // read data, one cycle after rd
  output logic [2:0] active_source, // selected oscillator
  output logic [1:0] primary_submode, // fixed primary submode
  output logic [2:0] start_source, // source being started
  output logic start_en, // start requested source
  output logic secondary_on, // secondary oscillator enable
  output logic monitor_on, // fail-safe monitor enable
  output logic pin_freeze, // pin-map freeze state
  output logic [7:0] periph_div, // cpu to peripheral ratio
  output logic [8:0] frc_div, // fast rc divisor
  output logic signed [5:0] frc_trim // fast rc trim
);
  logic [2:0] cur_src;
  logic [2:0] new_src;
  logic sel_freeze;
  logic pll_ok;
  logic fail_flag;
  logic sec_en;
  logic sw_req;
  logic recover_on_interrupt;
  logic [2:0] ratio;
  logic ratio_en;
  logic [2:0] pst;
  logic [5:0] trim;
  logic [1:0] key_hi;
  logic [1:0] key_lo;
  logic [4:0] s1;
  logic [4:0] s2;
  logic tick_d;
  logic [3:0] settle_cnt;
  logic started;
  osd_pkg::osd_state_t state;
  wire sw_en = ~switch_monitor_cfg[1];
  wire mon_en = switch_monitor_cfg == 2'b00;
  wire wr_ctl = wr && addr == osd_pkg::ADDR_OSC_CTRL;
  wire hi_ok = key_hi == 2'd2;
  wire lo_ok = key_lo == 2'd2;
  wire hi_wr = wr_ctl && wbyte[1] && hi_ok;
  wire lo_wr = wr_ctl && wbyte[0] && lo_ok;
  wire i_intr = s2[0];
  wire i_fail = s2[1];
  wire i_ready = s2[2];
  wire i_lock = s2[3];
  wire tick_rise = s2[4] && !tick_d;
  wire sel_locked = sel_freeze && mon_en;
  function automatic logic uses_pll(input logic [2:0] src);
    uses_pll = src == osd_pkg::SRC_PRI_PLL || src == osd_pkg::SRC_FRC_PLL;
  endfunction
  function automatic logic [8:0] pst_div(input logic [2:0] code);
    pst_div = code == 3'h7 ? 9'h100 : 9'(9'h001 << code);
  endfunction
  // two-flop synchronisers
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s1 <= 5'h00;
      s2 <= 5'h00;
      tick_d <= 1'b0;
    end
    else
    begin
      s1 <= {new_clk_tick, pll_locked, source_ready, clock_failed, intr_evt};
      s2 <= s1;
      tick_d <= s2[4];
    end
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      key_hi <= 2'd0;
      key_lo <= 2'd0;
    end
    else if (wr_ctl)
    begin
      if (wbyte == 2'b10 && wdata[15:8] == osd_pkg::KEY_HI_1)
        key_hi <= 2'd1;
      else if (wbyte == 2'b10 && key_hi == 2'd1 && wdata[15:8] == osd_pkg::KEY_HI_2)
        key_hi <= 2'd2;
      else
        key_hi <= 2'd0;
      if (wbyte == 2'b01 && wdata[7:0] == osd_pkg::KEY_LO_1)
        key_lo <= 2'd1;
      else if (wbyte == 2'b01 && key_lo == 2'd1 && wdata[7:0] == osd_pkg::KEY_LO_2)
        key_lo <= 2'd2;
      else
        key_lo <= 2'd0;
    end
    else if (wr)
    begin
      key_hi <= 2'd0;
      key_lo <= 2'd0;
    end
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
      new_src <= osd_pkg::SRC_FRC_DIV;
    else if (!started)
      new_src <= initial_source_cfg;
    else if (hi_wr && !sel_locked)
      new_src <= wdata[osd_pkg::NEW_LSB +: 3];
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
      started <= 1'b0;
    else
      started <= 1'b1;
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      sel_freeze <= 1'b0;
      pin_freeze <= 1'b0;
      sec_en <= 1'b0;
    end
    else if (lo_wr)
    begin
      sel_freeze <= sel_freeze | wdata[osd_pkg::SELFRZ_BIT];
      sec_en <= wdata[osd_pkg::SECEN_BIT];
      if (!(one_way_freeze_cfg && pin_freeze))
        pin_freeze <= wdata[osd_pkg::PINFRZ_BIT];
    end
  end
  // fail flag, set wins over clear
  always_ff @(posedge clk)
  begin
    if (!nrst)
      fail_flag <= 1'b0;
    else if (i_fail && mon_en)
      fail_flag <= 1'b1;
    else if (state == osd_pkg::OSD_START)
      fail_flag <= 1'b0;
    else if (lo_wr && !wdata[osd_pkg::FAIL_BIT])
      fail_flag <= 1'b0;
  end
  // switch sequencer
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state <= osd_pkg::OSD_IDLE;
      sw_req <= 1'b0;
      cur_src <= osd_pkg::SRC_FRC_DIV;
      settle_cnt <= 4'h0;
    end
    else if (!sw_en || !started)
    begin
      state <= osd_pkg::OSD_IDLE;
      sw_req <= 1'b0;
      cur_src <= initial_source_cfg;
    end
    else
    begin
      case (state)
        osd_pkg::OSD_IDLE:
        begin
          if (lo_wr && wdata[osd_pkg::SWREQ_BIT] && !sel_locked)
          begin
            sw_req <= 1'b1;
            state <= osd_pkg::OSD_START;
          end
        end
        osd_pkg::OSD_START:
        begin
          if (new_src == cur_src)
          begin
            sw_req <= 1'b0;
            state <= osd_pkg::OSD_IDLE;
          end
          else
            state <= osd_pkg::OSD_SETTLE;
          settle_cnt <= 4'h0;
        end
        osd_pkg::OSD_SETTLE:
        begin
          // wait ready, lock, then ten new clocks
          if (i_ready && (!uses_pll(new_src) || i_lock) && tick_rise)
          begin
            if (settle_cnt == osd_pkg::SETTLE_CYCLES - 4'h1)
              state <= osd_pkg::OSD_DONE;
            else
              settle_cnt <= settle_cnt + 4'h1;
          end
        end
        osd_pkg::OSD_DONE:
        begin
          cur_src <= new_src;
          sw_req <= 1'b0;
          state <= osd_pkg::OSD_IDLE;
        end
        default:
          state <= osd_pkg::OSD_IDLE;
      endcase
    end
  end
  // cleared on switch or non-pll mode
  always_ff @(posedge clk)
  begin
    if (!nrst)
      pll_ok <= 1'b0;
    else if (state == osd_pkg::OSD_START || !uses_pll(cur_src))
      pll_ok <= 1'b0;
    else
      pll_ok <= i_lock;
  end
  // clock divider and trim registers
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      recover_on_interrupt <= 1'b0;
      ratio <= osd_pkg::RATIO_RESET;
      pst <= osd_pkg::PST_RESET;
      trim <= osd_pkg::TRIM_RESET;
    end
    else if (wr && addr == osd_pkg::ADDR_CLK_DIV)
    begin
      recover_on_interrupt <= wdata[osd_pkg::ROI_BIT];
      ratio <= wdata[osd_pkg::RATIO_LSB +: 3];
      pst <= wdata[osd_pkg::PST_LSB +: 3];
    end
    else if (wr && addr == osd_pkg::ADDR_TRIM)
      trim <= wdata[5:0];
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
      ratio_en <= 1'b0;
    else if (recover_on_interrupt && i_intr)
      ratio_en <= 1'b0;
    else if (wr && addr == osd_pkg::ADDR_CLK_DIV)
      ratio_en <= wdata[osd_pkg::RAEN_BIT];
  end
  // registered outputs
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      active_source <= osd_pkg::SRC_FRC_DIV;
      primary_submode <= osd_pkg::SUB_EXT;
      start_source <= osd_pkg::SRC_FRC_DIV;
      start_en <= 1'b0;
      secondary_on <= 1'b0;
      monitor_on <= 1'b0;
      periph_div <= 8'h01;
      frc_div <= 9'h002;
      frc_trim <= 6'sh00;
    end
    else
    begin
      active_source <= cur_src;
      primary_submode <= primary_submode_cfg;
      start_source <= new_src;
      start_en <= state == osd_pkg::OSD_SETTLE;
      secondary_on <= sec_en;
      monitor_on <= mon_en;
      periph_div <= ratio_en ? 8'(8'h01 << ratio) : 8'h01;
      frc_div <= pst_div(pst);
      frc_trim <= $signed(trim);
    end
  end
  // read data one cycle after strobe
  always_ff @(posedge clk)
  begin
    if (!nrst)
      rdata <= 16'h0000;
    else if (rd)
    begin
      case (addr)
        osd_pkg::ADDR_OSC_CTRL:
          rdata <= {1'b0, cur_src, 1'b0, new_src, sel_freeze, pin_freeze, pll_ok,
                    1'b0, fail_flag, 1'b0, sec_en, sw_req};
        osd_pkg::ADDR_CLK_DIV:
          rdata <= {recover_on_interrupt, ratio, ratio_en, pst, 8'h00};
        osd_pkg::ADDR_TRIM:
          rdata <= {10'h000, trim};
        default:
          rdata <= 16'h0000;
      endcase
    end
    else
      rdata <= 16'h0000;
  end
  // request never set while switching disabled
  AST_REQ_HELD: assert property (@(posedge clk) disable iff (!nrst)
    switch_monitor_cfg[1] && $past(switch_monitor_cfg[1]) |-> !sw_req)
    else $error("request set while switching disabled");
  AST_FREEZE_SET_ONLY: assert property (@(posedge clk) disable iff (!nrst)
    sel_freeze |=> sel_freeze)
    else $error("selection freeze cleared");
  AST_FAIL_SET: assert property (@(posedge clk) disable iff (!nrst)
    i_fail && mon_en |=> fail_flag)
    else $error("fail flag not set");
  sequence seq_start_equal;
    state == osd_pkg::OSD_START && new_src == cur_src;
  endsequence
  AST_ABORT: assert property (@(posedge clk) disable iff (!nrst)
    ((sw_en && started) and seq_start_equal) |=> !sw_req && cur_src == $past(cur_src))
    else $error("redundant switch not aborted");
  sequence seq_done;
    state == osd_pkg::OSD_DONE && sw_en;
  endsequence
  AST_SWITCH_DONE: assert property (@(posedge clk) disable iff (!nrst)
    seq_done |=> cur_src == $past(new_src) && !sw_req)
    else $error("switch completion wrong");
  AST_PLL_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
    !uses_pll($past(cur_src)) |-> !pll_ok)
    else $error("pll status set in non-pll mode");
  AST_ROI: assert property (@(posedge clk) disable iff (!nrst)
    recover_on_interrupt && i_intr |=> !ratio_en ##1 periph_div == 8'h01)
    else $error("ratio enable not cleared by interrupt");
  AST_PIN_ONE_WAY: assert property (@(posedge clk) disable iff (!nrst)
    one_way_freeze_cfg && pin_freeze |=> pin_freeze)
    else $error("one-way pin freeze cleared");
  // high byte changes only after unlock
  AST_UNLOCK_HI: assert property (@(posedge clk) disable iff (!nrst)
    started && $past(started) && new_src != $past(new_src) |-> $past(hi_wr))
    else $error("new source changed without unlock");
endmodule

// file: design/osd_pkg.sv
// constants for the oscillator select and doze control block
package osd_pkg;
  // register addresses on the plain register port
  localparam logic [1:0] ADDR_OSC_CTRL = 2'h0;
  localparam logic [1:0] ADDR_CLK_DIV = 2'h1;
  localparam logic [1:0] ADDR_TRIM = 2'h2;
  // oscillator_control field positions
  localparam int CUR_LSB = 12;
  localparam int NEW_LSB = 8;
  localparam int SELFRZ_BIT = 7;
  localparam int PINFRZ_BIT = 6;
  localparam int PLLOK_BIT = 5;
  localparam int FAIL_BIT = 3;
  localparam int SECEN_BIT = 1;
  localparam int SWREQ_BIT = 0;
  // clock_divider field positions
  localparam int ROI_BIT = 15;
  localparam int RATIO_LSB = 12;
  localparam int RAEN_BIT = 11;
  localparam int PST_LSB = 8;
  // reset values
  localparam logic [2:0] PST_RESET = 3'h1;
  localparam logic [2:0] RATIO_RESET = 3'h0;
  localparam logic [5:0] TRIM_RESET = 6'h00;
  // unlock keys
  localparam logic [7:0] KEY_HI_1 = 8'h78;
  localparam logic [7:0] KEY_HI_2 = 8'h9a;
  localparam logic [7:0] KEY_LO_1 = 8'h46;
  localparam logic [7:0] KEY_LO_2 = 8'h57;
  // source encodings
  localparam logic [2:0] SRC_FRC = 3'h0;
  localparam logic [2:0] SRC_FRC_PLL = 3'h1;
  localparam logic [2:0] SRC_PRI = 3'h2;
  localparam logic [2:0] SRC_PRI_PLL = 3'h3;
  localparam logic [2:0] SRC_SEC = 3'h4;
  localparam logic [2:0] SRC_FRC_DIV = 3'h7;
  // primary submodes
  localparam logic [1:0] SUB_EXT = 2'h0;
  localparam logic [1:0] SUB_XTAL = 2'h1;
  localparam logic [1:0] SUB_HS = 2'h2;
  // cycles of the new clock before the switch
  localparam logic [3:0] SETTLE_CYCLES = 4'ha;
  typedef enum logic [1:0] {
    OSD_IDLE = 2'b00,
    OSD_START = 2'b01,
    OSD_SETTLE = 2'b10,
    OSD_DONE = 2'b11
  } osd_state_t;
endpackage

// file: tb/osd_testbench.sv
// self-checking bench for the oscillator select and doze control block
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, one_way_freeze_cfg, wr, rd, intr_evt, clock_failed;
  logic source_ready, pll_locked, new_clk_tick, start_en, secondary_on, monitor_on, pin_freeze, e;
  logic [1:0] switch_monitor_cfg, primary_submode_cfg, addr, wbyte, primary_submode;
  logic [2:0] initial_source_cfg, active_source, start_source, r;
  logic [15:0] wdata, rdata, d;
  logic [7:0] periph_div;
  logic [8:0] frc_div;
  logic signed [5:0] frc_trim;
  logic [5:0] t;
  int err_count, checks;

  osd_ctrl dut (.clk, .nrst, .switch_monitor_cfg, .initial_source_cfg, .primary_submode_cfg,
    .one_way_freeze_cfg, .addr, .wdata, .wbyte, .wr, .rd, .intr_evt, .clock_failed, .source_ready,
    .pll_locked, .new_clk_tick, .rdata, .active_source, .primary_submode, .start_source, .start_en,
    .secondary_on, .monitor_on, .pin_freeze, .periph_div, .frc_div, .frc_trim);

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic done(input string n);
    $display("test %s finished, checks %0d", n, checks);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [1:0] a, input logic [15:0] v, input logic [1:0] l);
    addr <= a;
    wdata <= v;
    wbyte <= l;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // key pair on one lane, then the data write, all back to back
  task automatic wr_key(input logic [1:0] l, input logic [15:0] v);
    logic [15:0] k [3];
    k[0] = l[1] ? {osd_pkg::KEY_HI_1, 8'h00} : {8'h00, osd_pkg::KEY_LO_1};
    k[1] = l[1] ? {osd_pkg::KEY_HI_2, 8'h00} : {8'h00, osd_pkg::KEY_LO_2};
    k[2] = v;
    for (int i = 0; i < 3; i++)
    begin
      addr <= osd_pkg::ADDR_OSC_CTRL;
      wdata <= k[i];
      wbyte <= l;
      wr <= 1'b1;
      @(posedge clk);
    end
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [1:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
    #1;
  endtask

  task automatic tick_wait(input int n);
    repeat (n)
    begin
      @(posedge clk);
      new_clk_tick <= ~new_clk_tick;
    end
  endtask

  task automatic wait_switch();
    for (int i = 0; i <= 40; i++)
    begin
      if (i == 40)
      begin
        err_count++;
        report_and_stop();
      end
      tick_wait(4);
      rd_reg(osd_pkg::ADDR_OSC_CTRL);
      if (d[osd_pkg::SWREQ_BIT] === 1'b0)
        break;
    end
    rd_reg(osd_pkg::ADDR_OSC_CTRL);
  endtask

  function automatic logic [8:0] exp_frc(input logic [2:0] c);
    return (c == 3'h7) ? 9'h100 : 9'(1 << c);
  endfunction

  function automatic logic [7:0] exp_periph(input logic [2:0] c, input logic en);
    return en ? 8'(1 << c) : 8'h01;
  endfunction

  initial
  begin
    nrst = 1'b0;
    switch_monitor_cfg = 2'b00;
    initial_source_cfg = osd_pkg::SRC_FRC_DIV;
    primary_submode_cfg = osd_pkg::SUB_EXT;
    one_way_freeze_cfg = 1'b1;
    addr = 2'h0;
    wdata = 16'h0000;
    wbyte = 2'b00;
    wr = 1'b0;
    rd = 1'b0;
    intr_evt = 1'b0;
    clock_failed = 1'b0;
    source_ready = 1'b1;
    pll_locked = 1'b0;
    new_clk_tick = 1'b0;
    err_count = 0;
    checks = 0;
    void'($urandom(20));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    idle(3);
    `CHK(active_source, osd_pkg::SRC_FRC_DIV)
    `CHK(frc_div, 9'h002)
    `CHK(periph_div, 8'h01)
    `CHK(monitor_on, 1'b1)
    rd_reg(osd_pkg::ADDR_OSC_CTRL);
    `CHK(d, 16'h7700)
    rd_reg(osd_pkg::ADDR_CLK_DIV);
    `CHK(d, 16'h0100)
    rd_reg(osd_pkg::ADDR_TRIM);
    `CHK(d, 16'h0000)
    done("reset");
    for (int i = 0; i < 8; i++)
    begin
      r = 3'($urandom());
      e = 1'($urandom());
      wr_reg(osd_pkg::ADDR_CLK_DIV, {1'b0, r, e, 3'(i), 8'hff}, 2'b11);
      rd_reg(osd_pkg::ADDR_CLK_DIV);
      `CHK(d, {1'b0, r, e, 3'(i), 8'h00})
      `CHK(frc_div, exp_frc(3'(i)))
      `CHK(periph_div, exp_periph(r, e))
    end
    done("divider");
    for (int i = 0; i < 2; i++)
    begin
      wr_reg(osd_pkg::ADDR_CLK_DIV, i == 0 ? 16'hb800 : 16'h3800, 2'b11);
      intr_evt <= 1'b1;
      idle(2);
      intr_evt <= 1'b0;
      idle(4);
      `CHK(periph_div, i == 0 ? 8'h01 : 8'h08)
      rd_reg(osd_pkg::ADDR_CLK_DIV);
      `CHK(d, i == 0 ? 16'hb000 : 16'h3800)
    end
    done("recover");
    for (int i = 0; i < 4; i++)
    begin
      t = (i == 0) ? 6'h1f : (i == 1) ? 6'h20 : 6'($urandom());
      wr_reg(osd_pkg::ADDR_TRIM, {10'h3ff, t}, 2'b11);
      rd_reg(osd_pkg::ADDR_TRIM);
      `CHK(d, {10'h000, t})
      `CHK(frc_trim, t)
    end
    done("trim");
    wr_reg(osd_pkg::ADDR_OSC_CTRL, 16'h0000, 2'b10);
    rd_reg(osd_pkg::ADDR_OSC_CTRL);
    `CHK(d[10:8], osd_pkg::SRC_FRC_DIV)
    wr_key(2'b10, {5'h00, osd_pkg::SRC_FRC, 8'h00});
    rd_reg(osd_pkg::ADDR_OSC_CTRL);
    `CHK(d[10:8], osd_pkg::SRC_FRC)
    wr_key(2'b01, 16'h0001);
    wait_switch();
    `CHK(d[14:12], osd_pkg::SRC_FRC)
    `CHK(active_source, osd_pkg::SRC_FRC)
    wr_key(2'b01, 16'h0001);
    idle(3);
    rd_reg(osd_pkg::ADDR_OSC_CTRL);
    `CHK(d[0], 1'b0)
    `CHK(start_en, 1'b0)
    done("switch");
    wr_key(2'b10, {5'h00, osd_pkg::SRC_PRI_PLL, 8'h00});
    wr_key(2'b01, 16'h0001);
    tick_wait(60);
    rd_reg(osd_pkg::ADDR_OSC_CTRL);
    `CHK(d[0], 1'b1)
    `CHK(d[5], 1'b0)
    `CHK(start_en, 1'b1)
    `CHK(start_source, osd_pkg::SRC_PRI_PLL)
    pll_locked <= 1'b1;
    wait_switch();
    `CHK(d[14:12], osd_pkg::SRC_PRI_PLL)
    `CHK(d[5], 1'b1)
    // leave pll mode via plain fast rc
    wr_key(2'b10, {5'h00, osd_pkg::SRC_FRC, 8'h00});
    wr_key(2'b01, 16'h0001);
    wait_switch();
    `CHK(d[5], 1'b0)
    done("pll");
    clock_failed <= 1'b1;
    idle(3);
    clock_failed <= 1'b0;
    idle(4);
    rd_reg(osd_pkg::ADDR_OSC_CTRL);
    `CHK(d[3], 1'b1)
    wr_reg(osd_pkg::ADDR_OSC_CTRL, 16'h0040, 2'b01);
    rd_reg(osd_pkg::ADDR_OSC_CTRL);
    `CHK(pin_freeze, 1'b0)
    wr_key(2'b01, 16'h0042);
    rd_reg(osd_pkg::ADDR_OSC_CTRL);
    `CHK(pin_freeze, 1'b1)
    `CHK(secondary_on, 1'b1)
    `CHK(d[3], 1'b0)
    wr_key(2'b01, 16'h0080);
    rd_reg(osd_pkg::ADDR_OSC_CTRL);
    `CHK(d[7], 1'b1)
    `CHK(pin_freeze, 1'b1)
    `CHK(secondary_on, 1'b0)
    wr_key(2'b01, 16'h0000);
    wr_key(2'b10, {5'h00, osd_pkg::SRC_SEC, 8'h00});
    rd_reg(osd_pkg::ADDR_OSC_CTRL);
    `CHK(d[7], 1'b1)
    `CHK(d[10:8], osd_pkg::SRC_FRC)
    done("locks");
    switch_monitor_cfg <= 2'b10;
    initial_source_cfg <= osd_pkg::SRC_PRI;
    primary_submode_cfg <= osd_pkg::SUB_XTAL;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    idle(3);
    `CHK(active_source, osd_pkg::SRC_PRI)
    `CHK(primary_submode, osd_pkg::SUB_XTAL)
    `CHK(monitor_on, 1'b0)
    wr_key(2'b10, {5'h00, osd_pkg::SRC_FRC, 8'h00});
    wr_key(2'b01, 16'h0001);
    tick_wait(30);
    rd_reg(osd_pkg::ADDR_OSC_CTRL);
    `CHK(d[0], 1'b0)
    `CHK(d[14:12], osd_pkg::SRC_PRI)
    `CHK(active_source, osd_pkg::SRC_PRI)
    done("disabled");
    report_and_stop();
  end
endmodule
